// *** dv/pcisa_chk.sv ***
// Concurrent checks on the wires between the device end and the host end
`timescale 1ns/1ps
`default_nettype none
module pcisa_chk (
	input wire logic        ref_clk,
	input wire logic        nrst,
	input wire logic        bus_reset_in_n,
	input wire logic [31:0] ad,
	input wire logic [3:0]  cbe,
	input wire logic        par,
	input wire logic        perr_n,
	input wire logic        clkrun_n,
	input wire logic [31:0] dev_ad_o,
	input wire logic        dev_ad_oe_n,
	input wire logic [3:0]  dev_cbe_o,
	input wire logic        dev_cbe_oe_n,
	input wire logic        dev_par_o,
	input wire logic        dev_par_oe_n,
	input wire logic        dev_perr_oe_n,
	input wire logic        dev_clkrun_oe_n,
	input wire logic [31:0] host_ad_o,
	input wire logic        host_ad_oe_n,
	input wire logic [3:0]  host_cbe_o,
	input wire logic        host_cbe_oe_n,
	input wire logic        host_par_o,
	input wire logic        host_par_oe_n
);
	// Everything on the bus clock, quiet while the chip is reset
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	// Parity follows the drive by one clock and makes the ones count even
	property p_dev_par;
		!dev_ad_oe_n && bus_reset_in_n |=> !dev_par_oe_n && dev_par_o == ^{$past(dev_ad_o), $past(dev_cbe_o)};
	endproperty
	a_dev_par: assert property (p_dev_par) else $error("device parity late or wrong");
	property p_host_par;
		!host_ad_oe_n |=> !host_par_oe_n && host_par_o == ^{$past(host_ad_o), $past(host_cbe_o)};
	endproperty
	a_host_par: assert property (p_host_par) else $error("host parity late or wrong");
	property p_par_cause;
		!dev_par_oe_n |-> !$past(dev_ad_oe_n);
	endproperty
	a_par_cause: assert property (p_par_cause) else $error("parity driven without data");
	// Lanes travel with the address/data lines
	property p_cbe_with_ad;
		dev_cbe_oe_n == dev_ad_oe_n && host_cbe_oe_n == host_ad_oe_n;
	endproperty
	a_cbe_with_ad: assert property (p_cbe_with_ad) else $error("lanes not driven with data");
	// Bus reset floats every device output
	property p_float;
		!bus_reset_in_n |=> dev_ad_oe_n && dev_cbe_oe_n && dev_par_oe_n && dev_perr_oe_n && dev_clkrun_oe_n;
	endproperty
	a_float: assert property (p_float) else $error("output driven in bus reset");
	// Error pin only after a real mismatch
	property p_perr_cause;
		!perr_n |-> $past(par, 1) != ^{$past(ad, 2), $past(cbe, 2)};
	endproperty
	a_perr_cause: assert property (p_perr_cause) else $error("parity error without mismatch");
	// Clock-run hold lasts two cycles and starts only on a high line
	property p_hold_len;
		$fell(dev_clkrun_oe_n) && bus_reset_in_n |=> !dev_clkrun_oe_n ##1 dev_clkrun_oe_n;
	endproperty
	a_hold_len: assert property (p_hold_len) else $error("clock-run hold length wrong");
	property p_hold_line;
		$fell(dev_clkrun_oe_n) |-> $past(clkrun_n);
	endproperty
	a_hold_line: assert property (p_hold_line) else $error("clock-run hold on a low line");

	// Main traffic seen
	c_dev_drive: cover property (!dev_ad_oe_n);
	c_host_drive: cover property (!host_ad_oe_n);
	c_hold: cover property ($fell(dev_clkrun_oe_n));
	c_bus_reset: cover property (!bus_reset_in_n);
endmodule : pcisa_chk
`default_nettype wire

// *** dv/test_pci_system_and_ad_bus_port.sv ***
// Testbench for both ends of the bus system-signal and address/data port
`timescale 1ns/1ps
`default_nettype none
module test_pci_system_and_ad_bus_port;
	logic        ref_clk, nrst, d_drv, h_drv, d_chk, h_chk, chk2, is_a, busy, perr_en, hold_en;
	logic        chw, chv, rst_req, stop_req;
	logic [31:0] drv_ad;
	logic [3:0]  drv_cbe;
	logic        d_chc, d_rxv, d_rxa, d_perr, d_inrst, d_hold, d2_perr;
	logic        h_rxv, h_rxa, h_perr, h_pseen, stop_ok;
	logic [31:0] d_rxw, h_rxw;
	logic [3:0]  d_rxl, h_rxl;
	int          n_fail, n_compared;

	pcisa_if pcisa_if_inst (.ref_clk(ref_clk));
	pcisa_if pcisa_if_inst_b (.ref_clk(ref_clk));
	pcisa_dev pcisa_dev_inst (.ref_clk(ref_clk), .nrst(nrst), .bus(pcisa_if_inst), .drive_req(d_drv),
		.drive_ad(drv_ad), .drive_cbe(drv_cbe), .check_req(d_chk), .check_is_addr(is_a), .busy(busy),
		.perr_en(perr_en), .suspend_hold_en(hold_en), .clk_hold_we(chw), .clk_hold_val(chv),
		.clock_hold_control(d_chc), .rx_valid(d_rxv), .rx_is_addr(d_rxa), .rx_word(d_rxw), .rx_lanes(d_rxl),
		.perr_pulse(d_perr), .in_bus_reset(d_inrst), .clkrun_hold(d_hold));
	pcisa_host pcisa_host_inst (.ref_clk(ref_clk), .nrst(nrst), .bus(pcisa_if_inst), .bus_reset_req(rst_req),
		.drive_req(h_drv), .drive_ad(drv_ad), .drive_cbe(drv_cbe), .check_req(h_chk), .check_is_addr(is_a),
		.clk_stop_req(stop_req), .rx_valid(h_rxv), .rx_is_addr(h_rxa), .rx_word(h_rxw), .rx_lanes(h_rxl),
		.par_err(h_perr), .perr_seen(h_pseen), .clk_stop_ok(stop_ok));
	// Second device faces the bench, which breaks parity on purpose
	pcisa_dev pcisa_dev_inst_b (.ref_clk(ref_clk), .nrst(nrst), .bus(pcisa_if_inst_b), .drive_req(1'b0),
		.drive_ad(32'h0000_0000), .drive_cbe(4'h0), .check_req(chk2), .check_is_addr(is_a), .busy(busy),
		.perr_en(perr_en), .suspend_hold_en(hold_en), .clk_hold_we(chw), .clk_hold_val(chv),
		.clock_hold_control(), .rx_valid(), .rx_is_addr(), .rx_word(), .rx_lanes(), .perr_pulse(d2_perr),
		.in_bus_reset(), .clkrun_hold());
	pcisa_chk pcisa_chk_inst (.ref_clk(ref_clk), .nrst(nrst), .bus_reset_in_n(pcisa_if_inst.bus_reset_in_n),
		.ad(pcisa_if_inst.ad), .cbe(pcisa_if_inst.cbe), .par(pcisa_if_inst.par), .perr_n(pcisa_if_inst.perr_n),
		.clkrun_n(pcisa_if_inst.clkrun_n), .dev_ad_o(pcisa_if_inst.dev_ad_o),
		.dev_ad_oe_n(pcisa_if_inst.dev_ad_oe_n), .dev_cbe_o(pcisa_if_inst.dev_cbe_o),
		.dev_cbe_oe_n(pcisa_if_inst.dev_cbe_oe_n), .dev_par_o(pcisa_if_inst.dev_par_o),
		.dev_par_oe_n(pcisa_if_inst.dev_par_oe_n), .dev_perr_oe_n(pcisa_if_inst.dev_perr_oe_n),
		.dev_clkrun_oe_n(pcisa_if_inst.dev_clkrun_oe_n), .host_ad_o(pcisa_if_inst.host_ad_o),
		.host_ad_oe_n(pcisa_if_inst.host_ad_oe_n), .host_cbe_o(pcisa_if_inst.host_cbe_o),
		.host_cbe_oe_n(pcisa_if_inst.host_cbe_oe_n), .host_par_o(pcisa_if_inst.host_par_o),
		.host_par_oe_n(pcisa_if_inst.host_par_oe_n));

	// Bus clock, 4 ns period
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Verdict and end of run
	task automatic stop_test;
		$display("compared %0d mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test

	// Bytes whose active-low enable is high read as zero
	function automatic logic [31:0] masked(input logic [31:0] w, input logic [3:0] be_n);
		masked = w;
		for (int i = 0; i < 4; i++) begin
			if (be_n[i]) masked[i*8 +: 8] = 8'h00;
		end
	endfunction : masked

	// One phase from one end to the other, then the parity verdict
	task automatic xfer(input logic to_dev, input logic a, input logic [31:0] w, input logic [3:0] c);
		@(posedge ref_clk);
		drv_ad <= w;
		drv_cbe <= c;
		is_a <= a;
		h_drv <= to_dev;
		d_drv <= !to_dev;
		@(posedge ref_clk);
		h_drv <= 1'b0;
		d_drv <= 1'b0;
		d_chk <= to_dev;
		h_chk <= !to_dev;
		@(posedge ref_clk);
		d_chk <= 1'b0;
		h_chk <= 1'b0;
		@(negedge ref_clk);
		chk(to_dev ? {d_rxv, d_rxa, d_rxl} : {h_rxv, h_rxa, h_rxl}, {1'b1, a, c});
		chk(to_dev ? d_rxw : h_rxw, a ? w : masked(w, c));
		@(posedge ref_clk);
		@(negedge ref_clk);
		chk(to_dev ? {d_perr, pcisa_if_inst.perr_n} : {h_perr, 1'b1}, 2'b01);
	endtask : xfer

	// Bench drives a data phase with wrong parity into the second device
	task automatic bad_par(input logic en);
		@(posedge ref_clk);
		perr_en <= en;
		is_a <= 1'b0;
		pcisa_if_inst_b.host_ad_oe_n <= 1'b0;
		pcisa_if_inst_b.host_cbe_oe_n <= 1'b0;
		pcisa_if_inst_b.host_ad_o <= 32'h1234_5678;
		pcisa_if_inst_b.host_cbe_o <= 4'h0;
		chk2 <= 1'b1;
		@(posedge ref_clk);
		pcisa_if_inst_b.host_ad_oe_n <= 1'b1;
		pcisa_if_inst_b.host_cbe_oe_n <= 1'b1;
		pcisa_if_inst_b.host_par_oe_n <= 1'b0;
		pcisa_if_inst_b.host_par_o <= ~^{32'h1234_5678, 4'h0};
		chk2 <= 1'b0;
		@(posedge ref_clk);
		pcisa_if_inst_b.host_par_oe_n <= 1'b1;
		@(negedge ref_clk);
		chk({d2_perr, pcisa_if_inst_b.perr_n}, {1'b1, !en});
	endtask : bad_par

	// Bus reset with drive requests arriving inside it
	task automatic bus_reset(input logic keep);
		@(posedge ref_clk);
		hold_en <= keep;
		rst_req <= 1'b1;
		repeat (3) @(posedge ref_clk);
		d_drv <= 1'b1;
		repeat (2) @(negedge ref_clk);
		chk({pcisa_if_inst.dev_ad_oe_n, pcisa_if_inst.dev_cbe_oe_n, pcisa_if_inst.dev_par_oe_n,
			pcisa_if_inst.dev_perr_oe_n, pcisa_if_inst.dev_clkrun_oe_n, d_inrst}, 6'h3f);
		@(posedge ref_clk);
		d_drv <= 1'b0;
		rst_req <= 1'b0;
		repeat (4) @(negedge ref_clk);
	endtask : bus_reset

	// Hang guard, far beyond the expected run of about 140 cycles
	initial begin
		repeat (3000) @(posedge ref_clk);
		n_fail++;
		stop_test();
	end

	// Main sequence
	initial begin
		{nrst, d_drv, h_drv, d_chk, h_chk, chk2, is_a, busy, perr_en, hold_en, chw, chv, rst_req, stop_req} = '0;
		drv_ad = 32'h0000_0000;
		drv_cbe = 4'h0;
		n_fail = 0;
		n_compared = 0;
		{pcisa_if_inst_b.host_ad_oe_n, pcisa_if_inst_b.host_cbe_oe_n, pcisa_if_inst_b.host_par_oe_n} = 3'h7;
		{pcisa_if_inst_b.host_clkrun_oe_n, pcisa_if_inst_b.bus_reset_in_n} = 2'h3;
		{pcisa_if_inst_b.host_ad_o, pcisa_if_inst_b.host_cbe_o, pcisa_if_inst_b.host_par_o} = '0;
		repeat (8) @(posedge ref_clk);
		nrst <= 1'b1;
		@(negedge ref_clk);
		chk(d_chc, 1'b1);
		xfer(1'b0, 1'b1, 32'h8000_1004, 4'h6);
		xfer(1'b0, 1'b0, 32'hdead_beef, 4'h5);
		xfer(1'b1, 1'b1, 32'h0000_0a0c, 4'h7);
		for (int i = 0; i < 16; i++) begin
			xfer(1'b1, 1'b0, 32'hc3a5_5a3c ^ i, i[3:0]);
		end
		bad_par(1'b1);
		bad_par(1'b0);
		// Idle bus reads as ones, so the pulled-up parity mismatches
		@(posedge ref_clk);
		perr_en <= 1'b1;
		d_chk <= 1'b1;
		@(posedge ref_clk);
		d_chk <= 1'b0;
		@(negedge ref_clk);
		@(negedge ref_clk);
		chk({d_perr, pcisa_if_inst.perr_n, h_perr}, 3'b100);
		@(negedge ref_clk);
		chk(h_pseen, 1'b1);
		@(posedge ref_clk);
		stop_req <= 1'b1;
		for (int i = 0; i < 12 && stop_ok !== 1'b1; i++) @(negedge ref_clk);
		chk(stop_ok, 1'b1);
		@(posedge ref_clk);
		busy <= 1'b1;
		for (int i = 0; i < 8 && d_hold !== 1'b1; i++) @(negedge ref_clk);
		chk(d_hold, 1'b1);
		repeat (2) @(negedge ref_clk);
		chk(stop_ok, 1'b0);
		@(posedge ref_clk);
		chw <= 1'b1;
		chv <= 1'b0;
		@(posedge ref_clk);
		chw <= 1'b0;
		for (int i = 0; i < 16 && stop_ok !== 1'b1; i++) @(negedge ref_clk);
		chk({d_chc, stop_ok}, 2'b01);
		@(posedge ref_clk);
		busy <= 1'b0;
		stop_req <= 1'b0;
		xfer(1'b1, 1'b0, 32'h5a5a_0f0f, 4'h0);
		bus_reset(1'b1);
		chk(d_chc, 1'b0);
		chk(d_rxw, 32'h5a5a_0f0f);
		bus_reset(1'b0);
		chk(d_chc, 1'b1);
		chk(d_rxw, 32'h0000_0000);
		xfer(1'b0, 1'b1, 32'h0000_0ff0, 4'ha);
		stop_test();
	end
endmodule : test_pci_system_and_ad_bus_port
`default_nettype wire

// *** hdl/pcisa_dev.sv ***
// Device end: bus reset, clock-run answer, address/data drive and parity
`timescale 1ns/1ps
`default_nettype none
module pcisa_dev (
	input  wire logic                          ref_clk,
	input  wire logic                          nrst,
	pcisa_if.dev                               bus,
	// Drive request: ad/lanes go out on the next edge
	input  wire logic                          drive_req,
	input  wire logic [pcisa_pkg::AD_W-1:0]    drive_ad,
	input  wire logic [pcisa_pkg::CBE_W-1:0]   drive_cbe,
	// Sample request: this edge is an address or data phase to take
	input  wire logic                          check_req,
	input  wire logic                          check_is_addr,
	// Activity pending or in progress
	input  wire logic                          busy,
	// Command word bit: parity-error reporting enable
	input  wire logic                          perr_en,
	// Low-power hold mode
	input  wire logic                          suspend_hold_en,
	// System control clock-hold write port
	input  wire logic                          clk_hold_we,
	input  wire logic                          clk_hold_val,
	output var  logic                          clock_hold_control,
	output var  logic                          rx_valid,
	output var  logic                          rx_is_addr,
	output var  logic [pcisa_pkg::AD_W-1:0]    rx_word,
	output var  logic [pcisa_pkg::CBE_W-1:0]   rx_lanes,
	output var  logic                          perr_pulse,
	output var  logic                          in_bus_reset,
	output var  logic                          clkrun_hold
);
	typedef enum logic [0:0] {
		PCISA_CR_IDLE,
		PCISA_CR_HOLD
	} pcisa_cr_state_t;

	logic                          bus_rst;
	logic                          clr;
	logic                          mismatch;
	logic                          need_clk;
	logic [pcisa_pkg::AD_W-1:0]    ad_out_reg;
	logic                          ad_oe_n_reg;
	logic [pcisa_pkg::CBE_W-1:0]   cbe_out_reg;
	logic                          par_out_reg;
	logic                          par_oe_n_reg;
	logic                          perr_oe_n_reg;
	logic                          chk_pend_reg;
	logic                          chk_par_reg;
	logic                          clk_hold_reg;
	logic                          clkrun_oe_n_reg;
	logic [1:0]                    cr_cnt_reg;
	pcisa_cr_state_t               cr_state_reg;
	logic                          rx_valid_reg;
	logic                          rx_is_addr_reg;
	logic [pcisa_pkg::AD_W-1:0]    rx_word_reg;
	logic [pcisa_pkg::CBE_W-1:0]   rx_lanes_reg;
	logic                          perr_pulse_reg;
	logic                          in_rst_reg;
	logic                          clkrun_hold_reg;

	// Bus reset taken as a synchronous level, sampled on the rising edge
	assign bus_rst  = ~bus.bus_reset_in_n; // see (RQ1)
	// Registers clear only outside hold mode
	assign clr      = bus_rst & ~suspend_hold_en; // see (RQ4) see (RQ6)
	// Parity compare one edge after the sampled phase
	assign mismatch = chk_pend_reg & (chk_par_reg != bus.par); // see (RQ13)
	// Own need for the bus clock
	assign need_clk = busy | drive_req | check_req | chk_pend_reg | ~ad_oe_n_reg | ~par_oe_n_reg;

	// Clock-hold control bit, preserved across bus reset in hold mode
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			clk_hold_reg <= pcisa_pkg::CLKHOLD_RST; // see (RQ3)
		end else if (clr) begin
			clk_hold_reg <= pcisa_pkg::CLKHOLD_RST; // see (RQ4)
		end else if (!bus_rst && clk_hold_we) begin
			clk_hold_reg <= clk_hold_val; // see (RQ5)
		end
	end

	// Address/data and lane drivers
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ad_oe_n_reg <= 1'b1;
			ad_out_reg  <= pcisa_pkg::AD_RST;
			cbe_out_reg <= pcisa_pkg::CBE_RST;
		end else if (bus_rst) begin
			ad_oe_n_reg <= 1'b1; // see (RQ4) see (RQ6)
			if (clr) begin
				ad_out_reg  <= pcisa_pkg::AD_RST;
				cbe_out_reg <= pcisa_pkg::CBE_RST;
			end
		end else begin
			// Address or data word with command or byte enables
			ad_oe_n_reg <= ~drive_req; // see (RQ7) see (RQ8)
			if (drive_req) begin
				ad_out_reg  <= drive_ad;
				cbe_out_reg <= drive_cbe; // see (RQ9) see (RQ10)
			end
		end
	end

	// Parity driven one clock after the word it covers
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			par_oe_n_reg <= 1'b1;
			par_out_reg  <= 1'b0;
		end else begin
			par_oe_n_reg <= bus_rst | ad_oe_n_reg; // see (RQ12)
			par_out_reg  <= pcisa_pkg::even_par(ad_out_reg, cbe_out_reg); // see (RQ11) see (RQ12)
		end
	end

	// Capture parity of the sampled phase
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			chk_pend_reg <= 1'b0;
			chk_par_reg  <= 1'b0;
		end else begin
			chk_pend_reg <= check_req & ~bus_rst; // see (RQ5)
			chk_par_reg  <= pcisa_pkg::even_par(bus.ad, bus.cbe); // see (RQ11)
		end
	end

	// Parity-error pin and status pulse
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			perr_oe_n_reg  <= 1'b1;
			perr_pulse_reg <= 1'b0;
		end else begin
			perr_oe_n_reg  <= ~(mismatch & perr_en & ~bus_rst); // see (RQ13) see (RQ14)
			perr_pulse_reg <= mismatch & ~bus_rst; // see (RQ13)
		end
	end

	// Received word: address as is, data masked by byte enables
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rx_valid_reg   <= 1'b0;
			rx_is_addr_reg <= 1'b0;
			rx_word_reg    <= pcisa_pkg::AD_RST;
			rx_lanes_reg   <= pcisa_pkg::CBE_RST;
		end else if (clr) begin
			rx_valid_reg   <= 1'b0;
			rx_is_addr_reg <= 1'b0;
			rx_word_reg    <= pcisa_pkg::AD_RST;
			rx_lanes_reg   <= pcisa_pkg::CBE_RST;
		end else begin
			rx_valid_reg <= check_req & ~bus_rst; // see (RQ5)
			if (check_req && !bus_rst) begin
				rx_is_addr_reg <= check_is_addr;
				rx_lanes_reg   <= bus.cbe; // see (RQ9) see (RQ10)
				if (check_is_addr) begin
					rx_word_reg <= bus.ad; // see (RQ7)
				end else begin
					rx_word_reg <= pcisa_pkg::be_mask(bus.ad, bus.cbe); // see (RQ8) see (RQ10)
				end
			end
		end
	end

	// Clock-run answer: pull the line low for two cycles when the clock is still needed and the line is high
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cr_state_reg    <= PCISA_CR_IDLE;
			cr_cnt_reg      <= 2'h0;
			clkrun_oe_n_reg <= 1'b1;
		end else if (bus_rst) begin
			cr_state_reg    <= PCISA_CR_IDLE;
			cr_cnt_reg      <= 2'h0;
			clkrun_oe_n_reg <= 1'b1; // see (RQ4)
		end else begin
			unique case (cr_state_reg)
				PCISA_CR_IDLE: begin
					// Line high means a stop or slow request
					if (clk_hold_reg && need_clk && bus.clkrun_n) begin
						cr_state_reg    <= PCISA_CR_HOLD; // see (RQ2) see (RQ3) see (RQ15)
						cr_cnt_reg      <= pcisa_pkg::CLKRUN_HOLD_CYC - 2'h1;
						clkrun_oe_n_reg <= 1'b0;
					end
				end
				PCISA_CR_HOLD: begin
					if (cr_cnt_reg == 2'h0) begin
						cr_state_reg    <= PCISA_CR_IDLE;
						clkrun_oe_n_reg <= 1'b1;
					end else begin
						cr_cnt_reg <= cr_cnt_reg - 2'h1;
					end
				end
			endcase
		end
	end

	// Status flops
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			in_rst_reg      <= 1'b0;
			clkrun_hold_reg <= 1'b0;
		end else begin
			in_rst_reg      <= bus_rst;
			clkrun_hold_reg <= ~bus_rst & clk_hold_reg & need_clk & bus.clkrun_n & (cr_state_reg == PCISA_CR_IDLE);
		end
	end

	// Pin drivers straight from flops
	assign bus.dev_ad_o        = ad_out_reg;
	assign bus.dev_ad_oe_n     = ad_oe_n_reg;
	assign bus.dev_cbe_o       = cbe_out_reg;
	assign bus.dev_cbe_oe_n    = ad_oe_n_reg;
	assign bus.dev_par_o       = par_out_reg;
	assign bus.dev_par_oe_n    = par_oe_n_reg;
	assign bus.dev_perr_o      = 1'b0;
	assign bus.dev_perr_oe_n   = perr_oe_n_reg;
	assign bus.dev_clkrun_o    = 1'b0;
	assign bus.dev_clkrun_oe_n = clkrun_oe_n_reg;

	// User-side outputs
	assign clock_hold_control = clk_hold_reg;
	assign rx_valid           = rx_valid_reg;
	assign rx_is_addr         = rx_is_addr_reg;
	assign rx_word            = rx_word_reg;
	assign rx_lanes           = rx_lanes_reg;
	assign perr_pulse         = perr_pulse_reg;
	assign in_bus_reset       = in_rst_reg;
	assign clkrun_hold        = clkrun_hold_reg;
endmodule : pcisa_dev
`default_nettype wire

// *** hdl/pcisa_host.sv ***
// Host end: bus reset source, central clock-run resource, drive and parity
`timescale 1ns/1ps
`default_nettype none
module pcisa_host (
	input  wire logic                          ref_clk,
	input  wire logic                          nrst,
	pcisa_if.host                              bus,
	input  wire logic                          bus_reset_req,
	input  wire logic                          drive_req,
	input  wire logic [pcisa_pkg::AD_W-1:0]    drive_ad,
	input  wire logic [pcisa_pkg::CBE_W-1:0]   drive_cbe,
	input  wire logic                          check_req,
	input  wire logic                          check_is_addr,
	input  wire logic                          clk_stop_req,
	output var  logic                          rx_valid,
	output var  logic                          rx_is_addr,
	output var  logic [pcisa_pkg::AD_W-1:0]    rx_word,
	output var  logic [pcisa_pkg::CBE_W-1:0]   rx_lanes,
	output var  logic                          par_err,
	output var  logic                          perr_seen,
	output var  logic                          clk_stop_ok
);
	logic                          rst_n_reg;
	logic [pcisa_pkg::AD_W-1:0]    ad_out_reg;
	logic                          ad_oe_n_reg;
	logic [pcisa_pkg::CBE_W-1:0]   cbe_out_reg;
	logic                          par_out_reg;
	logic                          par_oe_n_reg;
	logic                          chk_pend_reg;
	logic                          chk_par_reg;
	logic                          rx_valid_reg;
	logic                          rx_is_addr_reg;
	logic [pcisa_pkg::AD_W-1:0]    rx_word_reg;
	logic [pcisa_pkg::CBE_W-1:0]   rx_lanes_reg;
	logic                          par_err_reg;
	logic                          perr_seen_reg;
	logic                          clkrun_oe_n_reg;
	logic [2:0]                    quiet_cnt_reg;
	logic                          stop_ok_reg;

	// Bus reset output, asserted from chip reset
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_n_reg <= 1'b0;
		end else begin
			rst_n_reg <= ~bus_reset_req;
		end
	end

	// Word drive and parity one clock later
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ad_oe_n_reg  <= 1'b1;
			ad_out_reg   <= pcisa_pkg::AD_RST;
			cbe_out_reg  <= pcisa_pkg::CBE_RST;
			par_oe_n_reg <= 1'b1;
			par_out_reg  <= 1'b0;
		end else begin
			ad_oe_n_reg  <= ~drive_req; // see (RQ7) see (RQ8)
			if (drive_req) begin
				ad_out_reg  <= drive_ad;
				cbe_out_reg <= drive_cbe; // see (RQ9) see (RQ10)
			end
			par_oe_n_reg <= ad_oe_n_reg;
			par_out_reg  <= pcisa_pkg::even_par(ad_out_reg, cbe_out_reg);
		end
	end

	// Sampling of device words and parity check
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			chk_pend_reg   <= 1'b0;
			chk_par_reg    <= 1'b0;
			rx_valid_reg   <= 1'b0;
			rx_is_addr_reg <= 1'b0;
			rx_word_reg    <= pcisa_pkg::AD_RST;
			rx_lanes_reg   <= pcisa_pkg::CBE_RST;
			par_err_reg    <= 1'b0;
			perr_seen_reg  <= 1'b0;
		end else begin
			chk_pend_reg <= check_req; // see (RQ1)
			chk_par_reg  <= pcisa_pkg::even_par(bus.ad, bus.cbe);
			rx_valid_reg <= check_req;
			if (check_req) begin
				rx_is_addr_reg <= check_is_addr;
				rx_lanes_reg   <= bus.cbe;
				rx_word_reg    <= check_is_addr ? bus.ad : pcisa_pkg::be_mask(bus.ad, bus.cbe); // see (RQ7) see (RQ8)
			end
			par_err_reg   <= chk_pend_reg & (chk_par_reg != bus.par);
			perr_seen_reg <= ~bus.perr_n;
		end
	end

	// Central resource: hold line low, release to ask for a stop
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			clkrun_oe_n_reg <= 1'b0;
			quiet_cnt_reg   <= 3'h0;
			stop_ok_reg     <= 1'b0;
		end else begin
			clkrun_oe_n_reg <= clk_stop_req;
			if (!clk_stop_req || !clkrun_oe_n_reg || !bus.clkrun_n) begin
				quiet_cnt_reg <= 3'h0;
				stop_ok_reg   <= 1'b0;
			end else if (quiet_cnt_reg != pcisa_pkg::STOP_OK_CYC) begin
				quiet_cnt_reg <= quiet_cnt_reg + 3'h1;
				stop_ok_reg   <= 1'b0;
			end else begin
				stop_ok_reg <= 1'b1;
			end
		end
	end

	assign bus.bus_reset_in_n   = rst_n_reg;
	assign bus.host_ad_o        = ad_out_reg;
	assign bus.host_ad_oe_n     = ad_oe_n_reg;
	assign bus.host_cbe_o       = cbe_out_reg;
	assign bus.host_cbe_oe_n    = ad_oe_n_reg;
	assign bus.host_par_o       = par_out_reg;
	assign bus.host_par_oe_n    = par_oe_n_reg;
	assign bus.host_clkrun_o    = 1'b0;
	assign bus.host_clkrun_oe_n = clkrun_oe_n_reg;
	assign rx_valid             = rx_valid_reg;
	assign rx_is_addr           = rx_is_addr_reg;
	assign rx_word              = rx_word_reg;
	assign rx_lanes             = rx_lanes_reg;
	assign par_err              = par_err_reg;
	assign perr_seen            = perr_seen_reg;
	assign clk_stop_ok          = stop_ok_reg;
endmodule : pcisa_host
`default_nettype wire

// *** hdl/pcisa_if.sv ***
// Bus wires between the device end and the host end, with pin resolution
`timescale 1ns/1ps
`default_nettype none
interface pcisa_if (
	input wire logic ref_clk
);
	// Device-side drivers (output enables active low)
	logic [pcisa_pkg::AD_W-1:0]  dev_ad_o;
	logic                        dev_ad_oe_n;
	logic [pcisa_pkg::CBE_W-1:0] dev_cbe_o;
	logic                        dev_cbe_oe_n;
	logic                        dev_par_o;
	logic                        dev_par_oe_n;
	logic                        dev_perr_o;
	logic                        dev_perr_oe_n;
	logic                        dev_clkrun_o;
	logic                        dev_clkrun_oe_n;
	// Host-side drivers
	logic [pcisa_pkg::AD_W-1:0]  host_ad_o;
	logic                        host_ad_oe_n;
	logic [pcisa_pkg::CBE_W-1:0] host_cbe_o;
	logic                        host_cbe_oe_n;
	logic                        host_par_o;
	logic                        host_par_oe_n;
	logic                        host_clkrun_o;
	logic                        host_clkrun_oe_n;
	logic                        bus_reset_in_n;
	// Resolved wire levels
	logic [pcisa_pkg::AD_W-1:0]  ad;
	logic [pcisa_pkg::CBE_W-1:0] cbe;
	logic                        par;
	logic                        perr_n;
	logic                        clkrun_n;

	// Tri-state buses: the enabled driver wins, undriven reads as pulled high
	assign ad  = !dev_ad_oe_n ? dev_ad_o : (!host_ad_oe_n ? host_ad_o : '1);
	assign cbe = !dev_cbe_oe_n ? dev_cbe_o : (!host_cbe_oe_n ? host_cbe_o : '1);
	assign par = !dev_par_oe_n ? dev_par_o : (!host_par_oe_n ? host_par_o : 1'b1);
	assign perr_n = !dev_perr_oe_n ? dev_perr_o : 1'b1;
	// Open-drain clock-run line with pull-up
	assign clkrun_n = (!dev_clkrun_oe_n && !dev_clkrun_o) || (!host_clkrun_oe_n && !host_clkrun_o) ? 1'b0 : 1'b1;

	modport dev (
		input  ref_clk, ad, cbe, par, clkrun_n, bus_reset_in_n,
		output dev_ad_o, dev_ad_oe_n, dev_cbe_o, dev_cbe_oe_n, dev_par_o, dev_par_oe_n,
		output dev_perr_o, dev_perr_oe_n, dev_clkrun_o, dev_clkrun_oe_n
	);
	modport host (
		input  ref_clk, ad, cbe, par, perr_n, clkrun_n,
		output host_ad_o, host_ad_oe_n, host_cbe_o, host_cbe_oe_n, host_par_o, host_par_oe_n,
		output host_clkrun_o, host_clkrun_oe_n, bus_reset_in_n
	);
endinterface : pcisa_if
`default_nettype wire

// *** hdl/pcisa_pkg.sv ***
// Shared constants and helpers for the bus system-signal and address/data port
// Summary of operation
// (RQ1) Sample every bus signal on rising clock
// (RQ2) Answer clock-stop requests by own clock need
// (RQ3) Clock-run participation enabled after reset, control bit1
// (RQ4) Bus reset floats outputs, clears registers
// (RQ5) No function in reset, default after
// (RQ6) Hold mode: float outputs, keep registers
// (RQ7) Address phase carries 32-bit address
// (RQ8) Data phase carries the data word
// (RQ9) Address phase lanes carry bus command
// (RQ10) Data phase lanes are byte enables
// (RQ11) Even parity over address/data and lanes
// (RQ12) Initiator drives parity one clock later
// (RQ13) Target compares parity, flags mismatch
// (RQ14) Parity-error pin only when enabled, bit6
// (RQ15) Keep clock running while activity pending
package pcisa_pkg;
	// Bus widths
	localparam int AD_W   = 32;
	localparam int CBE_W  = 4;
	localparam int LANE_W = 8;
	// Control bit positions of the system control and command words
	localparam int SYSCTL_CLKHOLD_BIT = 1;
	localparam int CMD_PERR_EN_BIT    = 6;
	// Reset values
	localparam logic CLKHOLD_RST = 1'b1;
	localparam logic [AD_W-1:0] AD_RST = 32'h0000_0000;
	localparam logic [CBE_W-1:0] CBE_RST = 4'hf;
	// Clock-run timing: cycles the device holds the line low
	localparam logic [1:0] CLKRUN_HOLD_CYC = 2'h2;
	// Quiet cycles the central resource waits before stopping the clock
	localparam logic [2:0] STOP_OK_CYC = 3'h4;

	// Even parity bit: makes ones over address/data, lanes and parity even
	function automatic logic even_par(input logic [AD_W-1:0] ad, input logic [CBE_W-1:0] cbe);
		even_par = ^{ad, cbe}; // see (RQ11)
	endfunction : even_par

	// Zero the bytes whose active-low lane enable is high
	function automatic logic [AD_W-1:0] be_mask(input logic [AD_W-1:0] ad, input logic [CBE_W-1:0] cbe);
		be_mask = '0;
		for (int i = 0; i < CBE_W; i++) begin
			be_mask[i*LANE_W +: LANE_W] = cbe[i] ? 8'h00 : ad[i*LANE_W +: LANE_W]; // see (RQ10)
		end
	endfunction : be_mask
endpackage : pcisa_pkg
